/* File: src/thermostat_deadband_solenoid_hold.sv */
// option switch decode, setpoint hysteresis and solenoid hold control
`timescale 1ns/1ps
`default_nettype none
module thermostat_deadband_solenoid_hold
    import thermostat_cfg_pkg::*;
#(
    parameter int NUM_SOL = 3,
    parameter int PULL_IN_CYC = PULL_IN_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // option switches, sampled as steady levels
    input wire logic probe_one_range_sel,
    input wire logic overlay_button_lock,
    input wire logic hysteresis_sel_high,
    input wire logic hysteresis_sel_low,
    input wire logic units_fahrenheit,
    input wire logic pilot_continuous,
    input wire logic [2:0] hold_weight_sel,
    // overlay buttons, one-cycle pulses
    input wire logic button_up,
    input wire logic button_down,
    input wire logic button_target_two,
    // measurements in whole degrees celsius
    input wire logic signed [15:0] probe_one,
    input wire logic signed [15:0] probe_two,
    input wire logic display_probe_two,
    // solenoid requests from sequencing logic
    input wire logic [NUM_SOL-1:0] solenoid_request,
    output logic [NUM_SOL-1:0] solenoid_drive,
    output logic heat_call,
    output logic pilot_call,
    output logic probe_one_range_ok,
    output logic signed [15:0] display_value,
    output logic display_fahrenheit
);
    typedef struct packed {
        logic signed [15:0] sp_one;
        logic signed [15:0] sp_two;
        logic heat;
        logic range_ok;
        logic [31:0] rdata;
        logic signed [15:0] disp;
        logic disp_f;
        logic [15:0] step_cnt;
        logic [6:0] pct_phase;
    } state_t;

    state_t cur_ff;
    state_t nxt_cur;

    logic [NUM_SOL-1:0] holding;
    logic [3:0] db_c;
    logic [3:0] db_f;
    logic [6:0] hold_sum;
    logic buttons_ok;
    logic setup_phase;
    logic addr_hit;
    logic signed [16:0] on_threshold;
    logic signed [15:0] disp_src;
    logic signed [31:0] disp_f_wide;

    // celsius to fahrenheit, the nine-fifths product rounded toward zero before adding 32
    function automatic logic signed [31:0] to_fahr(
        input logic signed [15:0] c
    );
        logic signed [31:0] c_wide;
        c_wide = 32'(c);
        return (c_wide * 32'sd9) / 32'sd5 + 32'sd32;
    endfunction

    // deadband decode
    always_comb begin
        case ({hysteresis_sel_high, hysteresis_sel_low})
            2'b00: begin
                db_c = DB_C_00;
                db_f = DB_F_00;
            end
            2'b01: begin
                db_c = DB_C_01;
                db_f = DB_F_01;
            end
            2'b10: begin
                db_c = DB_C_10;
                db_f = DB_F_10;
            end
            2'b11: begin
                db_c = DB_C_11;
                db_f = DB_F_11;
            end
            default: begin
                db_c = DB_C_00;
                db_f = DB_F_00;
            end
        endcase
    end

    // hold duty: off switches add zero
    assign hold_sum = (hold_weight_sel[2] ? WEIGHT_40 : 7'h00)
                    + (hold_weight_sel[1] ? WEIGHT_20 : 7'h00)
                    + (hold_weight_sel[0] ? WEIGHT_10 : 7'h00);

    // lock input low is the enabled default
    assign buttons_ok = !overlay_button_lock;

    // turn-on point, widened so a low setpoint cannot wrap; it reads the
    // setpoint register directly so it tracks every write and button step
    always_comb begin
        on_threshold = 17'(cur_ff.sp_one) - $signed(17'(db_c));
    end

    assign disp_src = display_probe_two ? probe_two : probe_one;
    assign disp_f_wide = to_fahr(disp_src);

    // apb decode; zero wait states, reads captured in setup
    assign setup_phase = psel && !penable;
    always_comb begin
        case (paddr)
            OFF_SETPOINT_ONE,
            OFF_SETPOINT_TWO,
            OFF_STATUS,
            OFF_DISPLAY,
            OFF_DIP_ECHO: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    end

    // next state
    always_comb begin
        nxt_cur = cur_ff;

        // overlay buttons step the chosen setpoint by one degree
        if (buttons_ok && (button_up != button_down)) begin
            if (button_target_two) begin
                nxt_cur.sp_two = button_up ? cur_ff.sp_two + 16'sd1
                                           : cur_ff.sp_two - 16'sd1;
            end else begin
                nxt_cur.sp_one = button_up ? cur_ff.sp_one + 16'sd1
                                           : cur_ff.sp_one - 16'sd1;
            end
        end

        // bus write wins over a button press in the same cycle
        if (psel && penable && pwrite) begin
            case (paddr)
                OFF_SETPOINT_ONE: nxt_cur.sp_one = pwdata[15:0];
                OFF_SETPOINT_TWO: nxt_cur.sp_two = pwdata[15:0];
                default: nxt_cur.sp_one = nxt_cur.sp_one;
            endcase
        end

        // hysteresis: in the band the decision is left as it was
        if (17'(probe_one) < on_threshold) begin
            nxt_cur.heat = 1'b1;
        end else if (probe_one > cur_ff.sp_one) begin
            nxt_cur.heat = 1'b0;
        end

        // valid span of probe one follows the range switch
        if (probe_one_range_sel) begin
            nxt_cur.range_ok = (probe_one >= LOW_RANGE_MIN_C)
                            && (probe_one <= LOW_RANGE_MAX_C);
        end else begin
            nxt_cur.range_ok = (probe_one >= HIGH_RANGE_MIN_C)
                            && (probe_one <= HIGH_RANGE_MAX_C);
        end

        // display follows the units switch
        nxt_cur.disp_f = units_fahrenheit;
        if (units_fahrenheit) begin
            nxt_cur.disp = disp_f_wide[15:0];
        end else begin
            nxt_cur.disp = disp_src;
        end

        // fixed-period percent phase shared by every hold driver
        if (cur_ff.step_cnt >= 16'(PCT_STEP_CYCLES - 1)) begin
            nxt_cur.step_cnt = 16'h0;
            if (cur_ff.pct_phase >= PCT_FULL - 7'h01) begin
                nxt_cur.pct_phase = 7'h00;
            end else begin
                nxt_cur.pct_phase = cur_ff.pct_phase + 7'h01;
            end
        end else begin
            nxt_cur.step_cnt = cur_ff.step_cnt + 16'h1;
        end

        // read data captured during setup, stable through access
        if (setup_phase) begin
            nxt_cur.rdata = 32'h0;
            case (paddr)
                OFF_SETPOINT_ONE: nxt_cur.rdata = 32'(cur_ff.sp_one);
                OFF_SETPOINT_TWO: nxt_cur.rdata = 32'(cur_ff.sp_two);
                OFF_STATUS: begin
                    nxt_cur.rdata[ST_HEAT] = cur_ff.heat;
                    nxt_cur.rdata[ST_PILOT] = pilot_call;
                    nxt_cur.rdata[ST_RANGE_OK] = cur_ff.range_ok;
                    nxt_cur.rdata[ST_LOCKED] = overlay_button_lock;
                    nxt_cur.rdata[ST_FAHR] = units_fahrenheit;
                    nxt_cur.rdata[ST_DB_LSB +: 4] =
                        units_fahrenheit ? db_f : db_c;
                    nxt_cur.rdata[ST_SUM_LSB +: 7] = hold_sum;
                    nxt_cur.rdata[ST_HOLD_LSB +: NUM_SOL] = holding;
                end
                OFF_DISPLAY: nxt_cur.rdata = 32'(cur_ff.disp);
                OFF_DIP_ECHO: begin
                    nxt_cur.rdata[0] = probe_one_range_sel;
                    nxt_cur.rdata[1] = overlay_button_lock;
                    nxt_cur.rdata[2] = hysteresis_sel_low;
                    nxt_cur.rdata[3] = hysteresis_sel_high;
                    nxt_cur.rdata[4] = units_fahrenheit;
                    nxt_cur.rdata[5] = pilot_continuous;
                    nxt_cur.rdata[10:8] = hold_weight_sel;
                end
                default: nxt_cur.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_ff <= '{sp_one: RST_SETPOINT_ONE,
                        sp_two: RST_SETPOINT_TWO,
                        heat: 1'b0,
                        range_ok: 1'b0,
                        rdata: 32'h0,
                        disp: 16'sh0,
                        disp_f: 1'b0,
                        step_cnt: 16'h0,
                        pct_phase: 7'h00};
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // one hold driver per solenoid output
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SOL; gi++) begin : g_sol
            solenoid_hold_driver #(
                .PULL_IN_CYC(PULL_IN_CYC)
            ) u_drv (
                .pclk(pclk),
                .presetn(presetn),
                .request(solenoid_request[gi]),
                .pct_phase(cur_ff.pct_phase),
                .hold_sum(hold_sum),
                .drive(solenoid_drive[gi]),
                .holding(holding[gi])
            );
        end
    endgenerate

    assign heat_call = cur_ff.heat;
    // continuous pilot stays on; intermittent follows the heat call
    assign pilot_call = pilot_continuous || cur_ff.heat;
    assign probe_one_range_ok = cur_ff.range_ok;
    assign display_value = cur_ff.disp;
    assign display_fahrenheit = cur_ff.disp_f;
    assign prdata = cur_ff.rdata;
    assign pready = 1'b1;
    // unmapped addresses answer with an error in the access phase
    assign pslverr = psel && penable && !addr_hit;
endmodule
`default_nettype wire

/* File: common/thermostat_cfg_pkg.sv */
// shared constants for the thermostat deadband and solenoid hold block
package thermostat_cfg_pkg;
    // clock
    localparam int CLK_PERIOD_NS = 100;
    // apb register offsets (byte addresses)
    localparam logic [7:0] OFF_SETPOINT_ONE = 8'h00;
    localparam logic [7:0] OFF_SETPOINT_TWO = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_DISPLAY = 8'h0c;
    localparam logic [7:0] OFF_DIP_ECHO = 8'h10;
    // reset values of the setpoints, whole degrees celsius
    localparam logic signed [15:0] RST_SETPOINT_ONE = 16'sh0032;
    localparam logic signed [15:0] RST_SETPOINT_TWO = 16'sh012c;
    // status register field positions
    localparam int ST_HEAT = 0;
    localparam int ST_PILOT = 1;
    localparam int ST_RANGE_OK = 2;
    localparam int ST_LOCKED = 3;
    localparam int ST_FAHR = 4;
    localparam int ST_DB_LSB = 8;
    localparam int ST_SUM_LSB = 16;
    localparam int ST_HOLD_LSB = 24;
    // probe one spans in celsius; LOW_RANGE_MAX_F is the low-range top in fahrenheit
    localparam logic signed [15:0] HIGH_RANGE_MIN_C = -16'sd60;
    localparam logic signed [15:0] HIGH_RANGE_MAX_C = 16'sd1100;
    localparam logic signed [15:0] LOW_RANGE_MIN_C = 16'sd0;
    localparam logic signed [15:0] LOW_RANGE_MAX_C = 16'sd500;
    localparam logic signed [15:0] LOW_RANGE_MAX_F = 16'sd932;
    // deadband table, index {sel_high, sel_low}
    localparam logic [3:0] DB_C_00 = 4'h5;
    localparam logic [3:0] DB_C_01 = 4'h3;
    localparam logic [3:0] DB_C_10 = 4'h2;
    localparam logic [3:0] DB_C_11 = 4'h1;
    localparam logic [3:0] DB_F_00 = 4'ha;
    localparam logic [3:0] DB_F_01 = 4'h6;
    localparam logic [3:0] DB_F_10 = 4'h4;
    localparam logic [3:0] DB_F_11 = 4'h2;
    // hold driver switch weights, percent
    localparam logic [6:0] WEIGHT_40 = 7'h28;
    localparam logic [6:0] WEIGHT_20 = 7'h14;
    localparam logic [6:0] WEIGHT_10 = 7'h0a;
    localparam logic [6:0] PCT_FULL = 7'h64;
    // hold timing
    localparam int PULL_IN_MS = 100;
    localparam int PULL_IN_CYCLES = PULL_IN_MS * (1000000 / CLK_PERIOD_NS);
    localparam int HOLD_PERIOD_US = 1000;
    localparam int PCT_STEP_CYCLES =
        (HOLD_PERIOD_US * 1000 / CLK_PERIOD_NS) / 100;
    // hold driver states
    typedef enum logic [2:0] {
        HOLD_IDLE = 3'b001,
        HOLD_PULL = 3'b010,
        HOLD_TRIM = 3'b100
    } hold_state_t;
endpackage

/* File: src/solenoid_hold_driver.sv */
// one solenoid output: full-on pull-in, then trimmed hold duty
`timescale 1ns/1ps
`default_nettype none
module solenoid_hold_driver
    import thermostat_cfg_pkg::*;
#(
    parameter int PULL_IN_CYC = PULL_IN_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic request,
    input wire logic [6:0] pct_phase,
    input wire logic [6:0] hold_sum,
    output logic drive,
    output logic holding
);
    typedef struct packed {
        hold_state_t state;
        logic [31:0] timer;
        logic drive;
    } drv_t;

    drv_t cur_ff;
    drv_t nxt_cur;

    // pull in fully, then start trimming
    always_comb begin
        nxt_cur = cur_ff;
        case (cur_ff.state)
            HOLD_IDLE: begin
                nxt_cur.drive = 1'b0;
                nxt_cur.timer = 32'h0;
                if (request) begin
                    nxt_cur.state = HOLD_PULL;
                    nxt_cur.drive = 1'b1;
                end
            end
            HOLD_PULL: begin
                nxt_cur.drive = 1'b1;
                // trimming only after a full on-time has elapsed
                if (cur_ff.timer >= 32'(PULL_IN_CYC - 1)) begin
                    nxt_cur.state = HOLD_TRIM;
                end else begin
                    nxt_cur.timer = cur_ff.timer + 32'h1;
                end
            end
            HOLD_TRIM: begin
                // zero sum means no trimming at all, the safe side
                if (hold_sum == 7'h00) begin
                    nxt_cur.drive = 1'b1;
                end else begin
                    nxt_cur.drive = (pct_phase < hold_sum);
                end
            end
            default: begin
                nxt_cur.state = HOLD_IDLE;
                nxt_cur.drive = 1'b0;
            end
        endcase
        // dropping the request shuts the valve at once
        if (!request) begin
            nxt_cur.state = HOLD_IDLE;
            nxt_cur.drive = 1'b0;
            nxt_cur.timer = 32'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_ff <= '{state: HOLD_IDLE, timer: 32'h0, drive: 1'b0};
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign drive = cur_ff.drive;
    assign holding = (cur_ff.state == HOLD_TRIM);
endmodule
`default_nettype wire

/* File: verification/thermostat_hold_assertions.sv */
// port-level checker for the thermostat deadband and solenoid hold block
`timescale 1ns/1ps
`default_nettype none
module thermostat_hold_chk
    import thermostat_cfg_pkg::*;
#(
    parameter int NUM_SOL = 3,
    parameter int PULL_IN_CYC = PULL_IN_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pslverr,
    input wire logic probe_one_range_sel,
    input wire logic hysteresis_sel_high,
    input wire logic hysteresis_sel_low,
    input wire logic units_fahrenheit,
    input wire logic pilot_continuous,
    input wire logic button_up,
    input wire logic button_down,
    input wire logic signed [15:0] probe_one,
    input wire logic [NUM_SOL-1:0] solenoid_request,
    input wire logic [NUM_SOL-1:0] solenoid_drive,
    input wire logic heat_call,
    input wire logic pilot_call,
    input wire logic probe_one_range_ok,
    input wire logic display_fahrenheit
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // registered outputs lag one edge, so $past(presetn) skips the release
    logic mapped;
    assign mapped = paddr inside {OFF_SETPOINT_ONE, OFF_SETPOINT_TWO,
        OFF_STATUS, OFF_DISPLAY, OFF_DIP_ECHO};
    err_map_a: assert property (psel && penable |-> pslverr == !mapped)
        else $error("pslverr disagrees with the address map");
    pilot_follow_a: assert property (
        pilot_call == (pilot_continuous | heat_call))
        else $error("pilot call does not follow heat call");
    heat_steady_a: assert property (($past(presetn) && !psel &&
        !button_up && !button_down && $stable(probe_one) &&
        $stable({hysteresis_sel_high, hysteresis_sel_low}))[*3]
        |-> $stable(heat_call))
        else $error("heat call moved with steady inputs");
    range_low_a: assert property ($past(presetn) &&
        $past(probe_one_range_sel) |-> probe_one_range_ok ==
        ($past(probe_one) >= LOW_RANGE_MIN_C &&
        $past(probe_one) <= LOW_RANGE_MAX_C))
        else $error("low range flag wrong");
    range_high_a: assert property ($past(presetn) &&
        !$past(probe_one_range_sel) |-> probe_one_range_ok ==
        ($past(probe_one) >= HIGH_RANGE_MIN_C &&
        $past(probe_one) <= HIGH_RANGE_MAX_C))
        else $error("high range flag wrong");
    units_flag_a: assert property ($past(presetn) |->
        display_fahrenheit == $past(units_fahrenheit))
        else $error("units flag does not follow switch");
    drive_release_a: assert property ($past(presetn) |->
        (solenoid_drive & ~$past(solenoid_request)) == '0)
        else $error("solenoid driven without request");
    pull_in_a: assert property ($rose(solenoid_request[0]) ##1
        solenoid_request[0][*8] |-> solenoid_drive[0] &&
        $past(solenoid_drive[0], 7))
        else $error("solenoid not fully on during pull-in");
endmodule
bind thermostat_deadband_solenoid_hold thermostat_hold_chk #(
    .NUM_SOL(NUM_SOL), .PULL_IN_CYC(PULL_IN_CYC)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .paddr(paddr), .pslverr(pslverr),
    .probe_one_range_sel(probe_one_range_sel),
    .hysteresis_sel_high(hysteresis_sel_high),
    .hysteresis_sel_low(hysteresis_sel_low),
    .units_fahrenheit(units_fahrenheit),
    .pilot_continuous(pilot_continuous), .button_up(button_up),
    .button_down(button_down), .probe_one(probe_one),
    .solenoid_request(solenoid_request), .solenoid_drive(solenoid_drive),
    .heat_call(heat_call), .pilot_call(pilot_call),
    .probe_one_range_ok(probe_one_range_ok),
    .display_fahrenheit(display_fahrenheit));
`default_nettype wire

/* File: verification/valve_bank_model.sv */
// valve bank model: counts the cycles each coil is energised
`timescale 1ns/1ps
`default_nettype none
module valve_bank_model #(
    parameter int NUM_SOL = 3
) (
    input wire logic pclk,
    input wire logic clear,
    input wire logic [NUM_SOL-1:0] drive,
    output logic [NUM_SOL-1:0][15:0] on_cycles
);
    // a valve sees only its coil; on-time over a window gives the duty
    always_ff @(posedge pclk) begin
        for (int i = 0; i < NUM_SOL; i++) begin
            on_cycles[i] <= clear ? 16'h0000 : on_cycles[i] + 16'(drive[i]);
        end
    end
endmodule
`default_nettype wire

/* File: verification/thermostat_deadband_solenoid_hold_tb.sv */
// self-checking bench for the thermostat deadband and solenoid hold block
`timescale 1ns/1ps
`default_nettype none
module thermostat_deadband_solenoid_hold_tb;
    import thermostat_cfg_pkg::*;
    logic pclk, pready, pslverr, heat_call, pilot_call, err;
    logic probe_one_range_ok, display_fahrenheit;
    logic presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic probe_one_range_sel = 1'b0, overlay_button_lock = 1'b0;
    logic hysteresis_sel_high = 1'b0, hysteresis_sel_low = 1'b0;
    logic units_fahrenheit = 1'b0, pilot_continuous = 1'b0;
    logic button_up = 1'b0, button_down = 1'b0, button_target_two = 1'b0;
    logic display_probe_two = 1'b0, clear = 1'b0;
    logic [2:0] hold_weight_sel = 3'h0, solenoid_request = 3'h0;
    logic [2:0] solenoid_drive;
    logic signed [15:0] probe_one = 16'sd200, probe_two = 16'sd0;
    logic signed [15:0] display_value;
    logic [2:0][15:0] on_cycles;
    int n_mismatch = 0, tests_run = 0, s;
    int db[4] = '{5, 3, 2, 1};
    int hp[5] = '{100, 95, 94, 100, 101};
    int he[5] = '{0, 0, 1, 1, 0};
    int rp[5] = '{0, 500, 501, -1, 1100};
    logic [2:0] wt[5] = '{3'b100, 3'b010, 3'b001, 3'b111, 3'b000};

    // short pull-in keeps the run brief; trim timing is unchanged
    thermostat_deadband_solenoid_hold #(.NUM_SOL(3), .PULL_IN_CYC(20)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .probe_one_range_sel(probe_one_range_sel),
        .overlay_button_lock(overlay_button_lock),
        .hysteresis_sel_high(hysteresis_sel_high),
        .hysteresis_sel_low(hysteresis_sel_low),
        .units_fahrenheit(units_fahrenheit),
        .pilot_continuous(pilot_continuous),
        .hold_weight_sel(hold_weight_sel), .button_up(button_up),
        .button_down(button_down), .button_target_two(button_target_two),
        .probe_one(probe_one), .probe_two(probe_two),
        .display_probe_two(display_probe_two),
        .solenoid_request(solenoid_request),
        .solenoid_drive(solenoid_drive), .heat_call(heat_call),
        .pilot_call(pilot_call), .probe_one_range_ok(probe_one_range_ok),
        .display_value(display_value),
        .display_fahrenheit(display_fahrenheit));
    valve_bank_model #(.NUM_SOL(3)) u_valves (
        .pclk(pclk), .clear(clear), .drive(solenoid_drive),
        .on_cycles(on_cycles));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp, input string w);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %h want %h", $time, w, got, exp);
        end
    endtask

    // held until pready is seen high at a rising edge
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task press(input logic up);
        @(posedge pclk);
        button_up <= up;
        button_down <= !up;
        @(posedge pclk);
        button_up <= 1'b0;
        button_down <= 1'b0;
    endtask

    // counts exactly n edges of coil drive
    task measure(input int n);
        @(posedge pclk);
        clear <= 1'b1;
        @(posedge pclk);
        clear <= 1'b0;
        tick(n + 1);
    endtask

    task chk_all(input int e);
        for (int i = 0; i < 3; i++) begin
            chk(32'(on_cycles[i]), 32'(e), "coil on-time");
        end
    endtask

    task tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // watchdog: whole run is about 50k cycles
    initial begin
        tick(80000);
        n_mismatch++;
        $display("mismatch at %0t: watchdog expired", $time);
        tally_and_finish;
    end

    initial begin
        tick(8);
        presetn <= 1'b1;
        apb(1'b0, OFF_SETPOINT_ONE, 32'h0);
        chk(rd, 32'h00000032, "setpoint one reset");
        apb(1'b0, 8'h14, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped error");
        $display("test bus done");
        for (int i = 0; i < 8; i++) begin
            {units_fahrenheit, hysteresis_sel_high,
             hysteresis_sel_low} <= 3'(i);
            tick(3);
            apb(1'b0, OFF_STATUS, 32'h0);
            chk(32'(rd[11:8]), 32'(db[i % 4] * (i / 4 + 1)), "deadband");
        end
        {units_fahrenheit, hysteresis_sel_high, hysteresis_sel_low} <= 3'h0;
        $display("test deadband done");
        apb(1'b1, OFF_SETPOINT_ONE, 32'd100);
        foreach (hp[k]) begin
            probe_one <= 16'(hp[k]);
            tick(3);
            chk({31'h0, heat_call}, 32'(he[k]), "heat call");
            chk({31'h0, pilot_call}, 32'(he[k]), "pilot call");
        end
        pilot_continuous <= 1'b1;
        tick(2);
        chk({31'h0, pilot_call}, 32'h1, "continuous pilot");
        chk({31'h0, heat_call}, 32'h0, "heat with pilot");
        pilot_continuous <= 1'b0;
        $display("test hysteresis done");
        foreach (rp[k]) begin
            probe_one_range_sel <= (k < 4);
            probe_one <= 16'(rp[k]);
            tick(3);
            chk({31'h0, probe_one_range_ok}, 32'(k < 2 || k > 3),
                "range");
        end
        probe_one <= 16'sd100;
        tick(3);
        chk(32'(display_value), 32'd100, "celsius display");
        chk({31'h0, display_fahrenheit}, 32'h0, "units flag");
        units_fahrenheit <= 1'b1;
        tick(3);
        chk(32'(display_value), 32'd212, "fahrenheit display");
        chk({31'h0, display_fahrenheit}, 32'h1, "units flag f");
        display_probe_two <= 1'b1;
        probe_two <= -16'sd40;
        tick(3);
        chk(32'(display_value), 32'hffffffd8, "probe two display");
        apb(1'b0, OFF_DISPLAY, 32'h0);
        chk(rd, 32'hffffffd8, "display register");
        units_fahrenheit <= 1'b0;
        $display("test range and display done");
        press(1'b1);
        apb(1'b0, OFF_SETPOINT_ONE, 32'h0);
        chk(rd, 32'd101, "button accepted");
        overlay_button_lock <= 1'b1;
        press(1'b1);
        apb(1'b0, OFF_SETPOINT_ONE, 32'h0);
        chk(rd, 32'd101, "button locked");
        overlay_button_lock <= 1'b0;
        button_target_two <= 1'b1;
        press(1'b0);
        apb(1'b0, OFF_SETPOINT_TWO, 32'h0);
        chk(rd, 32'd299, "button on setpoint two");
        $display("test buttons done");
        hold_weight_sel <= 3'b001;
        solenoid_request <= 3'b111;
        measure(16);
        chk_all(16);
        foreach (wt[k]) begin
            hold_weight_sel <= wt[k];
            s = 40 * wt[k][2] + 20 * wt[k][1] + 10 * wt[k][0];
            tick(4);
            measure(10000);
            chk_all(s == 0 ? 10000 : s * 100);
            apb(1'b0, OFF_STATUS, 32'h0);
            chk(32'(rd[22:16]), 32'(s), "hold sum");
            chk(32'(rd[26:24]), 32'h7, "holding flags");
        end
        solenoid_request <= 3'b000;
        tick(2);
        measure(8);
        chk_all(0);
        $display("test solenoid hold done");
        tally_and_finish;
    end
endmodule
`default_nettype wire
